/* File: rtl/srfs_regs.v */
// APB register slice: SYSREF capture position status and input A full-scale range
//
// Contract
// - Read-only status filled by windowing logic
// - Capture position is 24 bits, 23:0
// - Input A range 16 bits, resets 0xA000
// - Range code maps monotonically to span
//
// Word map, byte addresses, one 32-bit word each:
//   0x02c capture position, read-only, bits 23:0
//   0x030 input A full-scale range, bits 15:0
//   0x034 status: position valid, range low, calibration pending
// Access is fixed: pready answers in the access cycle, no wait states.
`timescale 1ns/1ps
`include "srfs_map.vh"
module srfs_regs #(
  parameter POS_W   = `SRFS_CAPPOS_W,
  parameter RANGE_W = `SRFS_RANGEA_W
) (
  input  wire                    ref_clk,
  input  wire                    reset,
  input  wire                    psel,
  input  wire                    penable,
  input  wire                    pwrite,
  input  wire [`SRFS_ADDR_W-1:0] paddr,
  input  wire [31:0]             pwdata,
  input  wire [3:0]              pstrb,
  output reg  [31:0]             prdata,
  output reg                     pready,
  output reg                     pslverr,
  input  wire                    windowDone,
  input  wire                    sysrefEnabled,
  input  wire [POS_W-1:0]        windowPos,
  input  wire                    calDone,
  output reg  [RANGE_W-1:0]      inputAFullscaleRangeQ,
  output reg                     rangeChangedQ
);
  // ****************************************************************
  // Local constants
  // ****************************************************************
  // Byte lanes of the range word; pstrb has one bit per lane
  localparam BYTE_W = `SRFS_BYTE_W;
  localparam LANES  = RANGE_W / BYTE_W;

  // ****************************************************************
  // Address decode
  // ****************************************************************
  function isPos;
    input [`SRFS_ADDR_W-1:0] a;
    begin
      isPos = (a == `SRFS_OFF_CAPPOS);
    end
  endfunction

  function isRange;
    input [`SRFS_ADDR_W-1:0] a;
    begin
      isRange = (a == `SRFS_OFF_RANGEA);
    end
  endfunction

  function isStatus;
    input [`SRFS_ADDR_W-1:0] a;
    begin
      isStatus = (a == `SRFS_OFF_STATUS);
    end
  endfunction

  function mapped;
    input [`SRFS_ADDR_W-1:0] a;
    begin
      mapped = isPos(a) | isRange(a) | isStatus(a);
    end
  endfunction

  // Only the range word takes writes; both status words are read-only
  function writable;
    input [`SRFS_ADDR_W-1:0] a;
    begin
      writable = isRange(a);
    end
  endfunction

  // ****************************************************************
  // Bus phases
  // ****************************************************************
  wire                setup;
  wire                access;
  wire                wrHit;
  wire                rdSetup;
  wire                loadPos;
  wire                lowCode;
  wire [POS_W-1:0]    posQ;
  wire                posValid;
  wire [RANGE_W-1:0]  mergedRange;
  reg  [31:0]         rdData;

  // Next values of the registers
  reg  [RANGE_W-1:0]  inputAFullscaleRange_d;
  reg                 rangeChanged_d;
  reg                 pready_d;
  reg                 pslverr_d;
  reg  [31:0]         prdata_d;

  assign setup   = psel & ~penable;
  // A transfer completes at the edge where psel, penable and pready are high
  assign access  = psel & penable & pready;
  // Writes land only when the transfer completes, as the master expects
  assign wrHit   = access & pwrite & writable(paddr);
  assign rdSetup = setup & ~pwrite;

  // ****************************************************************
  // Capture position status
  // ****************************************************************
  // windowing fills status
  assign loadPos = windowDone & sysrefEnabled;

  // Position content is never reset; only its valid flag is
  srfs_capture_hold #(.WIDTH(POS_W)) uHold (
    .ref_clk (ref_clk),
    .reset   (reset),
    .load    (loadPos),
    .dataIn  (windowPos),
    .dataQ   (posQ),
    .validQ  (posValid)
  );

  // ****************************************************************
  // Range register and pending-calibration flag
  // ****************************************************************
  // byte lanes of a range write
  genvar lane;
  generate
    for (lane = 0; lane < LANES; lane = lane + 1) begin : gLane
      assign mergedRange[lane*BYTE_W +: BYTE_W] = pstrb[lane] ?
        pwdata[lane*BYTE_W +: BYTE_W] :
        inputAFullscaleRangeQ[lane*BYTE_W +: BYTE_W];
    end
  endgenerate

  always @* begin
    inputAFullscaleRange_d = inputAFullscaleRangeQ;
    rangeChanged_d         = rangeChangedQ;
    if (wrHit) begin
      inputAFullscaleRange_d = mergedRange;
    end
    // a write in the same cycle as cal done wins, so no change is lost
    if (wrHit) begin
      rangeChanged_d = 1'b1;
    end else if (calDone) begin
      rangeChanged_d = 1'b0;
    end
  end

  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      inputAFullscaleRangeQ <= `SRFS_RANGEA_RST;
      rangeChangedQ         <= 1'b0;
    end else begin
      inputAFullscaleRangeQ <= inputAFullscaleRange_d;
      rangeChangedQ         <= rangeChanged_d;
    end
  end

  // ****************************************************************
  // Read mux
  // ****************************************************************
  // codes below the recommended floor are flagged, not blocked
  assign lowCode = (inputAFullscaleRangeQ < `SRFS_RANGEA_MIN);

  // Unused upper bits of every word read as zero
  always @* begin
    rdData = `SRFS_ZERO32;
    case (paddr)
      `SRFS_OFF_CAPPOS: rdData[POS_W-1:0] = posQ;
      `SRFS_OFF_RANGEA: rdData[RANGE_W-1:0] = inputAFullscaleRangeQ;
      `SRFS_OFF_STATUS: begin
        rdData[`SRFS_ST_VALID_BIT] = posValid;
        rdData[`SRFS_ST_LOW_BIT]   = lowCode;
        rdData[`SRFS_ST_DIRTY_BIT] = rangeChangedQ;
      end
      default: rdData = `SRFS_ZERO32;
    endcase
  end

  // ****************************************************************
  // APB answer
  // ****************************************************************
  // Fixed one-cycle answer: pready rises in the access phase of every transfer
  always @* begin
    pready_d  = setup;
    // unmapped words refuse every access; read-only words refuse writes
    pslverr_d = setup & (~mapped(paddr) | (pwrite & ~writable(paddr)));
    prdata_d  = prdata;
    // Read data is caught in setup and stands until the next read
    if (rdSetup) begin
      prdata_d = rdData;
    end
  end

  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= `SRFS_ZERO32;
    end else begin
      pready  <= pready_d;
      pslverr <= pslverr_d;
      prdata  <= prdata_d;
    end
  end
endmodule // srfs_regs

/* File: rtl/srfs_map.vh */
// Register map constants for the SYSREF position and full-scale range bank
`ifndef SRFS_MAP_VH
`define SRFS_MAP_VH
`define SRFS_ADDR_W          12
`define SRFS_OFF_CAPPOS      12'h02c
`define SRFS_OFF_RANGEA      12'h030
`define SRFS_OFF_STATUS      12'h034
`define SRFS_CAPPOS_W        24
`define SRFS_RANGEA_W        16
`define SRFS_RANGEA_RST      16'ha000
`define SRFS_RANGEA_MIN      16'h2000
`define SRFS_BYTE_W          8
`define SRFS_ZERO32          32'h00000000
`define SRFS_ST_VALID_BIT    0
`define SRFS_ST_LOW_BIT      1
`define SRFS_ST_DIRTY_BIT    2
`endif

/* File: rtl/srfs_capture_hold.v */
// Holding register for the SYSREF capture-position word
`timescale 1ns/1ps
module srfs_capture_hold #(
  parameter WIDTH = 24
) (
  input  wire             ref_clk,
  input  wire             reset,
  input  wire             load,
  input  wire [WIDTH-1:0] dataIn,
  output reg  [WIDTH-1:0] dataQ,
  output reg              validQ
);
  // Content has no reset value; only the valid flag is cleared
  always @(posedge ref_clk) begin
    if (load) begin
      dataQ <= dataIn;
    end
  end

  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      validQ <= 1'b0;
    end else if (load) begin
      validQ <= 1'b1;
    end
  end
endmodule // srfs_capture_hold

/* File: testbench/srfs_regs_props.sv */
// Checker for the capture position and range register slice
`timescale 1ns/1ps
module srfs_regs_props (
  input wire logic        ref_clk,
  input wire logic        reset,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        windowDone,
  input wire logic        sysrefEnabled,
  input wire logic [23:0] windowPos,
  input wire logic        calDone,
  input wire logic [15:0] inputAFullscaleRangeQ,
  input wire logic        rangeChangedQ
);
  logic        rangeWr;
  logic [23:0] posQ;
  logic [15:0] lastWr;
  assign rangeWr = psel && penable && pready && pwrite && paddr == 12'h030;
  // Shadow of the last capture; a gated capture must leave it alone
  always_ff @(posedge ref_clk)
    if (windowDone && sysrefEnabled) posQ <= windowPos;
  // Writes with both range lanes strobed only, so the expected value needs no lane merge
  always_ff @(posedge ref_clk)
    if (rangeWr && pstrb[1:0] == 2'b11) lastWr <= pwdata[15:0];
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  a_ready_pulse: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("ready is not one access cycle");
  a_pos_readonly: assert property (pready && pwrite && paddr == 12'h02c |-> pslverr)
    else $error("position write not refused");
  a_pos_value: assert property (pready && !pwrite && paddr == 12'h02c |-> prdata == {8'h00, posQ})
    else $error("position read wrong");
  a_range_reset: assert property ($fell(reset) |-> inputAFullscaleRangeQ == 16'ha000)
    else $error("range reset value wrong");
  a_range_read: assert property (pready && !pwrite && paddr == 12'h030 |-> prdata == {16'h0000, inputAFullscaleRangeQ})
    else $error("range read wrong");
  a_range_write: assert property (rangeWr && pstrb[1:0] == 2'b11 |=> inputAFullscaleRangeQ == lastWr)
    else $error("range write not stored");
  a_write_dirty: assert property (rangeWr |=> rangeChangedQ)
    else $error("range write did not flag calibration");
  a_cal_clears: assert property (calDone && !rangeWr |=> !rangeChangedQ)
    else $error("cal done did not clear flag");
  a_status_ro: assert property (pready && pwrite && paddr == 12'h034 |-> pslverr)
    else $error("status write not refused");
endmodule // srfs_regs_props
bind srfs_regs srfs_regs_props i_srfs_regs_props (
  .ref_clk               (ref_clk),
  .reset                 (reset),
  .psel                  (psel),
  .penable               (penable),
  .pwrite                (pwrite),
  .paddr                 (paddr),
  .pwdata                (pwdata),
  .pstrb                 (pstrb),
  .prdata                (prdata),
  .pready                (pready),
  .pslverr               (pslverr),
  .windowDone            (windowDone),
  .sysrefEnabled         (sysrefEnabled),
  .windowPos             (windowPos),
  .calDone               (calDone),
  .inputAFullscaleRangeQ (inputAFullscaleRangeQ),
  .rangeChangedQ         (rangeChangedQ)
);

/* File: testbench/test_srfs_regs.sv */
// Bench for the capture position and range register slice
`timescale 1ns/1ps
module test_srfs_regs;
  logic        ref_clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        windowDone = 1'b0, sysrefEnabled = 1'b0, calDone = 1'b0;
  logic        pready, pslverr, rangeChangedQ;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, prdata;
  logic [3:0]  pstrb = 4'hf;
  logic [23:0] windowPos = 24'h000000;
  logic [15:0] inputAFullscaleRangeQ;
  int          errorCnt = 0, testsRun = 0;
  srfs_regs i_srfs_regs (
    .ref_clk               (ref_clk),
    .reset                 (reset),
    .psel                  (psel),
    .penable               (penable),
    .pwrite                (pwrite),
    .paddr                 (paddr),
    .pwdata                (pwdata),
    .pstrb                 (pstrb),
    .prdata                (prdata),
    .pready                (pready),
    .pslverr               (pslverr),
    .windowDone            (windowDone),
    .sysrefEnabled         (sysrefEnabled),
    .windowPos             (windowPos),
    .calDone               (calDone),
    .inputAFullscaleRangeQ (inputAFullscaleRangeQ),
    .rangeChangedQ         (rangeChangedQ)
  );
  initial forever #2 ref_clk = ~ref_clk;
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    testsRun++;
    if (g !== x) begin
      errorCnt++;
      $display("BAD %s exp %h got %h", nm, x, g);
    end
  endtask
  // Reads compare d with prdata; a refused access checks only the error flag
  task automatic xf(input logic w, input logic [11:0] a, input logic [31:0] d, input logic e);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge ref_clk) penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    chk("pslverr", {31'h0, e}, {31'h0, pslverr});
    if (!w && !e) chk("prdata", d, prdata);
    {psel, penable} <= 2'b00;
    @(posedge ref_clk);
  endtask
  task automatic closeOut;
    $display("errors %0d checks %0d", errorCnt, testsRun);
    if (errorCnt == 0 && testsRun > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    xf(1'b0, 12'h030, 32'h0000a000, 1'b0);
    chk("rangeChangedQ", 32'h00000000, {31'h0, rangeChangedQ});
    xf(1'b0, 12'h034, 32'h00000000, 1'b0);
    {windowDone, sysrefEnabled, windowPos} <= {2'b11, 24'hfedcba};
    @(posedge ref_clk) {sysrefEnabled, windowPos} <= {1'b0, 24'h123456};
    @(posedge ref_clk) windowDone <= 1'b0;
    xf(1'b0, 12'h02c, 32'h00fedcba, 1'b0);
    xf(1'b1, 12'h02c, 32'h00000001, 1'b1);
    xf(1'b0, 12'h02c, 32'h00fedcba, 1'b0);
    xf(1'b0, 12'h034, 32'h00000001, 1'b0);
    xf(1'b1, 12'h034, 32'h00000007, 1'b1);
    xf(1'b1, 12'h030, 32'hffff2000, 1'b0);
    chk("rangeChangedQ", 32'h00000001, {31'h0, rangeChangedQ});
    xf(1'b0, 12'h030, 32'h00002000, 1'b0);
    xf(1'b0, 12'h034, 32'h00000005, 1'b0);
    calDone <= 1'b1;
    @(posedge ref_clk) calDone <= 1'b0;
    @(posedge ref_clk);
    chk("rangeChangedQ", 32'h00000000, {31'h0, rangeChangedQ});
    xf(1'b0, 12'h034, 32'h00000001, 1'b0);
    xf(1'b1, 12'h030, 32'h00001000, 1'b0);
    chk("inputAFullscaleRangeQ", 32'h00001000, {16'h0000, inputAFullscaleRangeQ});
    xf(1'b0, 12'h034, 32'h00000007, 1'b0);
    pstrb <= 4'h2;
    xf(1'b1, 12'h030, 32'h0000a5ff, 1'b0);
    pstrb <= 4'hf;
    xf(1'b0, 12'h030, 32'h0000a500, 1'b0);
    xf(1'b1, 12'h030, 32'h0000ffff, 1'b0);
    xf(1'b0, 12'h030, 32'h0000ffff, 1'b0);
    xf(1'b0, 12'h040, 32'h00000000, 1'b1);
    reset <= 1'b1;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    chk("inputAFullscaleRangeQ", 32'h0000a000, {16'h0000, inputAFullscaleRangeQ});
    xf(1'b0, 12'h034, 32'h00000000, 1'b0);
    xf(1'b0, 12'h030, 32'h0000a000, 1'b0);
    closeOut();
  end
  initial begin
    repeat (500) @(posedge ref_clk);
    errorCnt++;
    closeOut();
  end
endmodule // test_srfs_regs
